/* core/pdcs_core.sv */
// Contract
// - Power down needs enable instruction just before
// - Active key-on condition wakes immediately
// - Pending timer 5 request wakes immediately
// - Five scratch registers undefined after wake-up
// - Z, D, E undefined after reset
// - Watchdog re-armed on every wake-up
// - No power down with external main clock
// - Main clock selectable once, others stop
// - Reset wait timed by on-chip oscillator
module pdcs_core (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Executed instruction strobes
  input  wire logic       instr_exec_i,
  input  wire logic       power_down_enable_instr_i,
  input  wire logic       power_down_instr_i,
  input  wire logic       power_down_alt_instr_i,
  input  wire logic       ceramic_clock_select_instr_i,
  input  wire logic       rc_clock_select_instr_i,
  // Wake sources
  input  wire logic [3:0] wakeup_control_first_i,
  input  wire logic [3:0] wakeup_control_second_i,
  input  wire logic [3:0] wakeup_control_third_i,
  input  wire logic [3:0] port_first_i,
  input  wire logic [3:0] port_second_i,
  input  wire logic       ext_irq_first_pin_i,
  input  wire logic       ext_irq_second_pin_i,
  input  wire logic       timer5_request_flag_i,
  // Configuration
  input  wire logic       ext_clock_mode_i,
  // Scratch register writes
  input  wire logic [4:0] reg_we_i,
  input  wire logic [7:0] reg_wdata_i,
  // Sequencer status
  output logic            cpu_run_o,
  output logic            power_down_o,
  output logic            wake_o,
  output logic            watchdog_rearm_o,
  output logic            stab_done_o,
  // Clock source control
  output logic            clk_selected_o,
  output logic            clk_ceramic_o,
  output logic            ceramic_osc_run_o,
  output logic            rc_osc_run_o,
  output logic            onchip_osc_run_o,
  // Scratch registers
  output logic [4:0]      reg_defined_o,
  output logic [1:0]      reg_z_o,
  output logic [3:0]      reg_x_o,
  output logic [3:0]      reg_y_o,
  output logic [2:0]      reg_d_o,
  output logic [7:0]      reg_e_o
);

  pdcs_pkg::pdcs_state_e state;
  pdcs_pkg::pdcs_state_e next_state;

  logic       pd_armed;
  logic       pd_instr;
  logic       pd_go;
  logic       keyon_hit;
  logic       wake_cond;
  logic       onchip_tick;
  logic [7:0] stab_cnt;
  logic       stab_end;
  logic       wake_evt;

  // On-chip oscillator ticks time the reset wait
  pdcs_tick_div #(
    .DIV (pdcs_pkg::ONCHIP_DIV)
  ) u_onchip_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (onchip_osc_run_o),
    .tick_o (onchip_tick)
  );

  // Stabilisation counter, runs only after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stab_cnt <= pdcs_pkg::STAB_CNT_RST;
    end else if (state == pdcs_pkg::ST_STAB && onchip_tick) begin
      stab_cnt <= stab_cnt + pdcs_pkg::STAB_CNT_ONE;
    end
  end

  assign stab_end = (stab_cnt == pdcs_pkg::STAB_TICKS);

  // Power-down enable holds only until the next instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_armed <= 1'b0;
    end else if (instr_exec_i && cpu_run_o) begin
      pd_armed <= power_down_enable_instr_i;
    end
  end

  assign pd_instr = instr_exec_i && cpu_run_o
                    && (power_down_instr_i || power_down_alt_instr_i);
  assign pd_go    = pd_instr && pd_armed && !ext_clock_mode_i;

  // Key-on return conditions: port pins low, interrupt pins by polarity
  always_comb begin
    keyon_hit = |(wakeup_control_first_i & ~port_first_i);
    keyon_hit = keyon_hit | (|(wakeup_control_second_i & ~port_second_i));
    if (wakeup_control_third_i[pdcs_pkg::WK2_FIRST_EN]
        && (ext_irq_first_pin_i
            == wakeup_control_third_i[pdcs_pkg::WK2_FIRST_POL])) begin
      keyon_hit = 1'b1;
    end
    if (wakeup_control_third_i[pdcs_pkg::WK2_SECOND_EN]
        && (ext_irq_second_pin_i
            == wakeup_control_third_i[pdcs_pkg::WK2_SECOND_POL])) begin
      keyon_hit = 1'b1;
    end
  end

  assign wake_cond = keyon_hit || timer5_request_flag_i;

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      pdcs_pkg::ST_STAB: begin
        if (stab_end) begin
          next_state = pdcs_pkg::ST_RUN;
        end
      end
      pdcs_pkg::ST_RUN: begin
        if (pd_go) begin
          next_state = pdcs_pkg::ST_DOWN;
        end
      end
      pdcs_pkg::ST_DOWN: begin
        if (wake_cond) begin
          next_state = pdcs_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = pdcs_pkg::ST_STAB;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= pdcs_pkg::ST_STAB;
    end else begin
      state <= next_state;
    end
  end

  assign wake_evt = (state == pdcs_pkg::ST_DOWN) && wake_cond;

  // Wake-up and watchdog re-arm pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o           <= 1'b0;
      watchdog_rearm_o <= 1'b0;
    end else begin
      wake_o           <= wake_evt;
      watchdog_rearm_o <= wake_evt;
    end
  end

  // Execution allowed only in run state
  assign cpu_run_o    = (state == pdcs_pkg::ST_RUN);
  assign power_down_o = (state == pdcs_pkg::ST_DOWN);
  assign stab_done_o  = (state != pdcs_pkg::ST_STAB);

  // One-time main clock selection, first instruction wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_selected_o <= 1'b0;
      clk_ceramic_o  <= 1'b0;
    end else if (!clk_selected_o && instr_exec_i && cpu_run_o) begin
      if (ceramic_clock_select_instr_i) begin
        clk_selected_o <= 1'b1;
        clk_ceramic_o  <= 1'b1;
      end else if (rc_clock_select_instr_i) begin
        clk_selected_o <= 1'b1;
        clk_ceramic_o  <= 1'b0;
      end
    end
  end

  // Oscillator enables: before selection all run, then only the chosen
  assign ceramic_osc_run_o = !clk_selected_o || clk_ceramic_o;
  assign rc_osc_run_o      = !clk_selected_o || !clk_ceramic_o;
  assign onchip_osc_run_o  = !clk_selected_o;

  // Defined status: writes set, wake-up clears all, reset sets only X and Y
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_defined_o <= pdcs_pkg::DEFINED_XY;
    end else if (wake_evt) begin
      reg_defined_o <= pdcs_pkg::DEFINED_RST;
    end else begin
      reg_defined_o <= reg_defined_o | reg_we_i;
    end
  end

  // Scratch registers; Z, D, E keep old contents across reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_x_o <= pdcs_pkg::XY_RST;
      reg_y_o <= pdcs_pkg::XY_RST;
    end else begin
      if (reg_we_i[pdcs_pkg::REG_X]) begin
        reg_x_o <= reg_wdata_i[pdcs_pkg::X_W-1:0];
      end
      if (reg_we_i[pdcs_pkg::REG_Y]) begin
        reg_y_o <= reg_wdata_i[pdcs_pkg::Y_W-1:0];
      end
    end
  end

  // Registers left undefined by reset, written only by software
  always_ff @(posedge clk_i) begin
    if (reg_we_i[pdcs_pkg::REG_Z] && !rst_i) begin
      reg_z_o <= reg_wdata_i[pdcs_pkg::Z_W-1:0];
    end
    if (reg_we_i[pdcs_pkg::REG_D] && !rst_i) begin
      reg_d_o <= reg_wdata_i[pdcs_pkg::D_W-1:0];
    end
    if (reg_we_i[pdcs_pkg::REG_E] && !rst_i) begin
      reg_e_o <= reg_wdata_i[pdcs_pkg::E_W-1:0];
    end
  end

endmodule

/* core/pdcs_pkg.sv */
package pdcs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_STAB = 3'h1,
    ST_RUN  = 3'h2,
    ST_DOWN = 3'h4
  } pdcs_state_e;

  // Clock rate of clk_i in kHz
  localparam int unsigned CLK_KHZ = 100000;

  // On-chip oscillator tick rate in kHz
  localparam int unsigned ONCHIP_KHZ = 25000;
  localparam int unsigned ONCHIP_DIV = CLK_KHZ / ONCHIP_KHZ;

  // Stabilisation wait in on-chip oscillator ticks
  localparam logic [7:0] STAB_TICKS   = 8'h40;
  localparam logic [7:0] STAB_CNT_RST = 8'h00;
  localparam logic [7:0] STAB_CNT_ONE = 8'h01;

  // Fields of the third wakeup control register
  localparam int unsigned WK2_FIRST_EN   = 0;
  localparam int unsigned WK2_FIRST_POL  = 1;
  localparam int unsigned WK2_SECOND_EN  = 2;
  localparam int unsigned WK2_SECOND_POL = 3;

  // Index of each scratch register in the defined-status vector
  localparam int unsigned REG_Z = 0;
  localparam int unsigned REG_X = 1;
  localparam int unsigned REG_Y = 2;
  localparam int unsigned REG_D = 3;
  localparam int unsigned REG_E = 4;

  // Widths of the scratch registers
  localparam int unsigned Z_W = 2;
  localparam int unsigned X_W = 4;
  localparam int unsigned Y_W = 4;
  localparam int unsigned D_W = 3;
  localparam int unsigned E_W = 8;

  // Reset values
  localparam logic [4:0] DEFINED_RST  = 5'h00;
  localparam logic [4:0] DEFINED_XY   = 5'h06;
  localparam logic [1:0] Z_RST        = 2'h0;
  localparam logic [3:0] XY_RST       = 4'h0;
  localparam logic [2:0] D_RST        = 3'h0;
  localparam logic [7:0] E_RST        = 8'h00;

endpackage

/* core/pdcs_tick_div.sv */
// Divider, cleared while run_i is low, giving a one-cycle enable every DIV clocks
module pdcs_tick_div #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic run_i,
  output logic      tick_o
);

  localparam logic [7:0] LAST = 8'(DIV - 1);
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [7:0] ONE  = 8'h01;

  logic [7:0] cnt;

  // Count while running, wrap at the last step
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= ZERO;
    end else if (cnt == LAST) begin
      cnt <= ZERO;
    end else begin
      cnt <= cnt + ONE;
    end
  end

  assign tick_o = run_i && (cnt == LAST);

endmodule

/* testbench/pdcs_core_assertions.sv */
module pdcs_core_assertions (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Inputs
  input wire logic       instr_exec_i,
  input wire logic       power_down_enable_instr_i,
  input wire logic       power_down_instr_i,
  input wire logic       power_down_alt_instr_i,
  input wire logic       timer5_request_flag_i,
  input wire logic       ext_clock_mode_i,
  // Outputs
  input wire logic       cpu_run_o,
  input wire logic       power_down_o,
  input wire logic       wake_o,
  input wire logic       watchdog_rearm_o,
  input wire logic       stab_done_o,
  input wire logic       clk_selected_o,
  input wire logic       clk_ceramic_o,
  input wire logic [4:0] reg_defined_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed;
  logic pd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Taken power-down instruction
  assign pd = cpu_run_o && instr_exec_i
    && (power_down_instr_i || power_down_alt_instr_i);
  // Last taken instruction was the enable
  always_ff @(posedge clk_i) begin
    if (rst_i) armed <= 1'b0;
    else if (cpu_run_o && instr_exec_i) armed <= power_down_enable_instr_i;
  end
  chk_pd_enter: assert property (pd && armed && !ext_clock_mode_i
    |=> power_down_o) else $error("no entry");
  chk_pd_refuse: assert property (pd && !armed |=> !power_down_o)
    else $error("bare entry");
  chk_ext_clock: assert property (pd && ext_clock_mode_i
    |=> !power_down_o) else $error("ext entry");
  chk_timer_wake: assert property (power_down_o && timer5_request_flag_i
    |=> !power_down_o && wake_o) else $error("no timer wake");
  chk_halt_down: assert property (power_down_o |-> !cpu_run_o)
    else $error("runs in down");
  chk_rearm_wake: assert property (watchdog_rearm_o == wake_o)
    else $error("rearm");
  chk_wake_undef: assert property (wake_o |-> reg_defined_o == 5'h00)
    else $error("defined");
  chk_clk_once: assert property (clk_selected_o
    |=> clk_selected_o && $stable(clk_ceramic_o)) else $error("reselect");
  chk_stab_wait: assert property ($fell(rst_i) |-> ##250 !stab_done_o
    ##[1:12] stab_done_o) else $error("stab time");
  // Main scenarios
  cover property (wake_o);
  cover property (pd && armed);
  cover property (clk_selected_o);
endmodule

/* testbench/pdcs_core_bench.sv */
module pdcs_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, instr_exec_i, ext_clock_mode_i, timer5_request_flag_i;
  logic power_down_enable_instr_i, power_down_instr_i, power_down_alt_instr_i;
  logic ceramic_clock_select_instr_i, rc_clock_select_instr_i;
  logic ext_irq_first_pin_i, ext_irq_second_pin_i, pol;
  logic [3:0] wakeup_control_first_i, wakeup_control_second_i;
  logic [3:0] wakeup_control_third_i, port_first_i, port_second_i;
  logic [4:0] reg_we_i, reg_defined_o;
  logic [7:0] reg_wdata_i, reg_e_o;
  logic cpu_run_o, power_down_o, wake_o, watchdog_rearm_o, stab_done_o;
  logic clk_selected_o, clk_ceramic_o, ceramic_osc_run_o, rc_osc_run_o;
  logic onchip_osc_run_o;
  logic [1:0] reg_z_o;
  logic [3:0] reg_x_o, reg_y_o;
  logic [2:0] reg_d_o;
  logic [7:0] dq[$];
  int mismatches, check_count, seed, n, m_def;
  // Clocks from reset release to the end of the stabilisation wait
  localparam int STAB_LEN =
    int'(pdcs_pkg::STAB_TICKS) * int'(pdcs_pkg::ONCHIP_DIV);
  pdcs_core dut_u (.*);
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Compare seen with expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Wait for execution after a reset release and check the wait length
  task automatic wait_run();
    n = 0;
    while (cpu_run_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= STAB_LEN && n < STAB_LEN + 14, 32'h1);
    chk(stab_done_o, 32'h1);
  endtask
  // One instruction: 0 enable, 1/2 power down, 3/4 clock select, 5 other
  task automatic exec(input int k);
    @(negedge clk_i);
    instr_exec_i = 1'b1;
    power_down_enable_instr_i = (k == 0);
    power_down_instr_i = (k == 1);
    power_down_alt_instr_i = (k == 2);
    ceramic_clock_select_instr_i = (k == 3);
    rc_clock_select_instr_i = (k == 4);
    @(negedge clk_i);
    {instr_exec_i, power_down_enable_instr_i, power_down_instr_i} = 3'h0;
    {power_down_alt_instr_i, ceramic_clock_select_instr_i} = 2'h0;
    rc_clock_select_instr_i = 1'b0;
  endtask
  // Wake source: 0 timer, 1/2 port pins, 3/4 ext pins
  task automatic src(input int i, input logic on);
    case (i)
      0: timer5_request_flag_i = on;
      1: port_first_i = on ? ~(4'h1 << ($random(seed) & 3)) : 4'hf;
      2: port_second_i = on ? 4'h7 : 4'hf;
      3: ext_irq_first_pin_i = on ~^ pol;
      default: ext_irq_second_pin_i = on ~^ pol;
    endcase
  endtask
  initial begin
    seed = 32'hee3c55ce;
    {mismatches, check_count} = 0;
    {instr_exec_i, ext_clock_mode_i, timer5_request_flag_i} = 3'h0;
    {power_down_enable_instr_i, power_down_instr_i} = 2'h0;
    {power_down_alt_instr_i, ceramic_clock_select_instr_i} = 2'h0;
    {rc_clock_select_instr_i, reg_we_i, reg_wdata_i} = 14'h0000;
    pol = $random(seed);
    {wakeup_control_first_i, wakeup_control_second_i} = 8'hff;
    wakeup_control_third_i = {pol, 1'b1, pol, 1'b1};
    {port_first_i, port_second_i} = 8'hff;
    {ext_irq_first_pin_i, ext_irq_second_pin_i} = {~pol, ~pol};
    rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    chk(reg_defined_o, 32'h06);
    wait_run();
    $display("reset test done");
    // Clock chosen once, as the first instruction after reset
    exec(3);
    exec(4);
    chk({clk_selected_o, clk_ceramic_o, ceramic_osc_run_o, rc_osc_run_o,
      onchip_osc_run_o}, 32'h1c);
    $display("clock test done");
    // Refused entries
    exec(1);
    chk(power_down_o, 32'h0);
    exec(0);
    exec(5);
    exec(2);
    chk(power_down_o, 32'h0);
    ext_clock_mode_i = 1'b1;
    exec(0);
    exec(1);
    chk(power_down_o, 32'h0);
    ext_clock_mode_i = 1'b0;
    // Entry, halt and wake by every source, both instructions
    for (int i = 0; i < 10; i++) begin
      // No interrupt or watchdog activity is driven around the entry
      exec(0);
      exec(1 + i % 2);
      chk(power_down_o, 32'h1);
      repeat (($random(seed) & 15) + 1) @(negedge clk_i);
      chk({power_down_o, cpu_run_o}, 32'h2);
      src(i / 2, 1'b1);
      @(negedge clk_i);
      chk({power_down_o, wake_o, watchdog_rearm_o}, 32'h3);
      chk(reg_defined_o, 32'h0);
      src(i / 2, 1'b0);
    end
    // Source already true at entry
    for (int i = 0; i < 5; i++) begin
      src(i, 1'b1);
      exec(0);
      exec(2);
      chk(power_down_o, 32'h1);
      @(negedge clk_i);
      chk({power_down_o, wake_o}, 32'h1);
      src(i, 1'b0);
    end
    $display("power down tests done");
    // Scratch register writes
    m_def = 0;
    for (int i = 0; i < 5; i++) begin
      reg_we_i = 5'h01 << i;
      reg_wdata_i = $random(seed);
      dq.push_back(reg_wdata_i);
      m_def = m_def | (1 << i);
      @(negedge clk_i);
      reg_we_i = 5'h00;
      chk(reg_defined_o, m_def);
    end
    chk({reg_e_o, reg_d_o, reg_y_o, reg_x_o, reg_z_o},
      {dq[4], dq[3][2:0], dq[2][3:0], dq[1][3:0], dq[0][1:0]});
    $display("scratch test done");
    // Reset in mid-run: selection cleared, only X and Y defined again
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk({clk_selected_o, onchip_osc_run_o, stab_done_o, cpu_run_o},
      32'h4);
    chk({reg_defined_o, reg_x_o, reg_y_o}, 32'h600);
    wait_run();
    $display("second reset test done");
    tally_and_finish();
  end
  // Watchdog on a hang
  initial begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
endmodule
bind pdcs_core pdcs_core_assertions chk_u (.*);
